// file: inc/low_alarm_pkg.sv
// constants and carrier types for the low alarm threshold and command read-back bank
package low_alarm_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 7;
  localparam int CMD_W = 16;
  localparam int CNT_W = 5;
  // register addresses and channel spacing
  localparam logic [ADDR_W-1:0] LOW_UPPER_BASE = 7'h18;
  localparam logic [ADDR_W-1:0] LOW_LOWER_BASE = 7'h19;
  localparam logic [ADDR_W-1:0] READBACK_ADDR = 7'h3f;
  localparam int CH_STRIDE = 5;
  // reset values
  localparam logic [7:0] LOW_UPPER_RST = 8'h00;
  localparam logic [3:0] LOW_LOWER_RST = 4'h0;
  localparam logic [CMD_W-1:0] CMD_RST = 16'h0000;
  // fixed fill: read-only nibble and trailing byte of every answer
  localparam logic [3:0] RO_NIBBLE = 4'h0;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  // frame bit positions (rising edge counts)
  localparam logic [CNT_W-1:0] CNT_CMD_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_RSP = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [3:0] lower;
  } thr_t;
endpackage

// file: rtl/alarm_low_threshold_and_cmd_readback.sv
// low alarm threshold registers and command read-back behind the serial link
// Contract
// - each channel has a read/write byte holding threshold bits 11:4, reset zero.
// - channel 0 upper byte sits at 18h, lower nibble register at 19h.
// - lower register bits 7:4 hold threshold bits 3:0, writable, reset zero.
// - lower register bits 3:0 read zero and ignore writes.
// - threshold is upper byte over lower nibble, left-justified to 16 bits.
// - address 3Fh returns the command word executed in the previous frame; the code returns only its upper byte, and only on a read.
// - returned word leaves msb first from the 16th falling serial edge.
// - first eight returned bits carry the command, next eight are zero.
// - previous command upper byte is an eight-bit read-only field, zero after reset.
module alarm_low_threshold_and_cmd_readback
  import low_alarm_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // thresholds and command seen by the core
  output logic [NUM_CH-1:0][CMD_W-1:0] low_level_o,
  output logic [7:0] prev_cmd_o
);
  logic frame_rst;
  logic [CMD_W-1:0] cmd_raw;
  cmd_t cmd;
  logic cmd_stb;
  logic [CMD_W-1:0] rsp_d;
  logic [CMD_W-1:0] last_cmd_q;
  // unpacked so each channel field has exactly one writing process
  thr_t thr_q [NUM_CH];
  logic chg_tgl_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic chg_seen;

  // chip select high ends the frame; a glitch on it only restarts framing
  assign frame_rst = !resetn_i || cs_n_i;
  assign cmd = cmd_t'(cmd_raw);

  serial_frame u_frame (
    .sclk_i(sclk_i),
    .frame_rst_i(frame_rst),
    .sdi_i(sdi_i),
    .rsp_i(rsp_d),
    .cmd_o(cmd_raw),
    .cmd_stb_o(cmd_stb),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o)
  );

  // ---------------- link clock domain ----------------

  // per-channel pairs, each decoded from its own address
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    localparam logic [ADDR_W-1:0] UP_ADDR = LOW_UPPER_BASE + ADDR_W'(g * CH_STRIDE);
    localparam logic [ADDR_W-1:0] LO_ADDR = LOW_LOWER_BASE + ADDR_W'(g * CH_STRIDE);

    always_ff @(posedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        thr_q[g].upper <= LOW_UPPER_RST;
      end else if (cmd_stb && cmd.wr && cmd.addr == UP_ADDR) begin
        thr_q[g].upper <= cmd.data;
      end
    end

    // only data bits 7:4 are stored; bits 3:0 have no storage
    always_ff @(posedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        thr_q[g].lower <= LOW_LOWER_RST;
      end else if (cmd_stb && cmd.wr && cmd.addr == LO_ADDR) begin
        thr_q[g].lower <= cmd.data[7:4];
      end
    end
  end

  // the command of every frame of 17 or more serial clocks becomes the previous command for the next frame
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_cmd_q <= CMD_RST;
    end else if (cmd_stb) begin
      last_cmd_q <= cmd_raw;
    end
  end

  // tell the system domain that link-side state moved
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chg_tgl_q <= 1'b0;
    end else if (cmd_stb) begin
      chg_tgl_q <= !chg_tgl_q;
    end
  end

  // answer is built from state before this frame's write lands
  always_comb begin
    rsp_d = '0;
    if (!cmd.wr && cmd.addr == READBACK_ADDR) begin
      rsp_d = {last_cmd_q[CMD_W-1:8], PAD_BYTE};
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (cmd.addr == LOW_UPPER_BASE + ADDR_W'(i * CH_STRIDE)) begin
        rsp_d = {thr_q[i].upper, PAD_BYTE};
      end
      if (cmd.addr == LOW_LOWER_BASE + ADDR_W'(i * CH_STRIDE)) begin
        rsp_d = {thr_q[i].lower, RO_NIBBLE, PAD_BYTE};
      end
    end
  end

  // ---------------- system clock domain ----------------

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= chg_tgl_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign chg_seen = sync2_q ^ sync3_q;

  // link-side words are stable for at least 16 serial clocks after a toggle,
  // far longer than the three system cycles this capture needs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_level_o <= '0;
    end else if (chg_seen) begin
      for (int i = 0; i < NUM_CH; i++) begin
        low_level_o[i] <= {thr_q[i].upper, thr_q[i].lower, RO_NIBBLE};
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_cmd_o <= CMD_RST[CMD_W-1:8];
    end else if (chg_seen) begin
      prev_cmd_o <= last_cmd_q[CMD_W-1:8];
    end
  end

  // ---------------- checks ----------------

  upper_write_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd_stb && cmd.wr && cmd.addr == LOW_UPPER_BASE) |=> (thr_q[0].upper == $past(cmd.data)))
    else $error("channel 0 upper byte not written");

  ch0_lower_addr_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd_stb && cmd.wr && cmd.addr == LOW_LOWER_BASE) |=> (thr_q[0].lower == $past(cmd.data[7:4])))
    else $error("channel 0 lower nibble not written at its address");

  lower_read_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd.addr == LOW_LOWER_BASE) |-> (rsp_d[15:12] == thr_q[0].lower))
    else $error("lower nibble does not read back");

  ro_nibble_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd.addr == LOW_LOWER_BASE + ADDR_W'(CH_STRIDE)) |-> (rsp_d[11:0] == 12'h000))
    else $error("read-only bits of lower register not zero");

  level_concat_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    chg_seen |=> (low_level_o[0] == {thr_q[0].upper, thr_q[0].lower, RO_NIBBLE}))
    else $error("effective threshold not upper over lower");

  readback_word_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd_stb && !cmd.wr && cmd.addr == READBACK_ADDR)
      |-> (rsp_d == {last_cmd_q[CMD_W-1:8], PAD_BYTE}))
    else $error("read-back answer is not the previous command");

  prev_cmd_track_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    cmd_stb |=> (last_cmd_q == $past(cmd_raw)))
    else $error("previous command not recorded");

  ch_isolation_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd_stb && cmd.addr == LOW_UPPER_BASE) |=> $stable(thr_q[1]))
    else $error("write to channel 0 changed channel 1");

  lower_isolation_a: assert property (
    @(posedge sclk_i) disable iff (!resetn_i)
    (cmd_stb && cmd.addr == LOW_LOWER_BASE) |=> $stable(thr_q[NUM_CH-1]))
    else $error("write to channel 0 changed the last channel");

  prev_cmd_copy_a: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    chg_seen |=> (prev_cmd_o == last_cmd_q[CMD_W-1:8]))
    else $error("previous command byte not copied to the core side");

  readback_c: cover property (
    @(posedge sclk_i) disable iff (!resetn_i)
    cmd_stb && !cmd.wr && cmd.addr == READBACK_ADDR && last_cmd_q != CMD_RST);

  lower_write_c: cover property (
    @(posedge sclk_i) disable iff (!resetn_i)
    cmd_stb && cmd.wr && cmd.addr == LOW_LOWER_BASE && cmd.data[3:0] != 4'h0);

  level_update_c: cover property (
    @(posedge clk_i) disable iff (!resetn_i)
    chg_seen ##1 low_level_o[0] != '0);

  other_ch_write_c: cover property (
    @(posedge sclk_i) disable iff (!resetn_i)
    cmd_stb && cmd.wr && cmd.addr == LOW_UPPER_BASE + ADDR_W'(CH_STRIDE));

  prev_cmd_update_c: cover property (
    @(posedge clk_i) disable iff (!resetn_i)
    chg_seen ##1 prev_cmd_o != '0);
endmodule

// file: rtl/serial_frame.sv
// serial frame engine: command shift-in and answer shift-out on the link clock
module serial_frame
  import low_alarm_pkg::*;
(
  // link
  input wire logic sclk_i,
  input wire logic frame_rst_i,
  input wire logic sdi_i,
  // answer for the current frame
  input wire logic [CMD_W-1:0] rsp_i,
  // captured command
  output logic [CMD_W-1:0] cmd_o,
  output logic cmd_stb_o,
  // serial output
  output logic sdo_o,
  output logic sdo_oe_o
);
  logic [CNT_W-1:0] cnt_q;
  logic [CMD_W-1:0] out_q;

  // frame_rst_i is chip select high or device reset; clears the frame state
  always_ff @(posedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      cmd_o <= CMD_RST;
    end else if (cnt_q <= CNT_CMD_LAST) begin
      cmd_o <= {cmd_o[CMD_W-2:0], sdi_i};
    end
  end

  // strobe stands for the one serial cycle after the 16th rising edge
  always_ff @(posedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      cmd_stb_o <= 1'b0;
    end else begin
      cmd_stb_o <= (cnt_q == CNT_CMD_LAST);
    end
  end

  // answer leaves msb first from the 16th falling edge on
  always_ff @(negedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      sdo_o <= 1'b0;
      out_q <= '0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= 1'b1;
      if (cnt_q == CNT_RSP) begin
        sdo_o <= rsp_i[CMD_W-1];
        out_q <= {rsp_i[CMD_W-2:0], 1'b0};
      end else if (cnt_q > CNT_RSP) begin
        sdo_o <= out_q[CMD_W-1];
        out_q <= {out_q[CMD_W-2:0], 1'b0};
      end else begin
        sdo_o <= 1'b0;
      end
    end
  end

  sdo_first_bit_a: assert property (
    @(negedge sclk_i) disable iff (frame_rst_i)
    ($past(cnt_q) == CNT_RSP) |-> (sdo_o == $past(rsp_i[CMD_W-1])))
    else $error("answer msb not on the 16th falling edge");

  sdo_quiet_early_a: assert property (
    @(negedge sclk_i) disable iff (frame_rst_i)
    ($past(cnt_q) < CNT_RSP) |-> !sdo_o)
    else $error("serial output driven before the 16th falling edge");
endmodule

// file: test/host_model.sv
// host controller model that runs serial frames on the link
module host_model
  import low_alarm_pkg::*;
(
  // link
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [CMD_W-1:0] rsp;
  event got;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // a read-back may stop at 24 clocks, the rest of the word stays 0
  task automatic frame(input logic [CMD_W-1:0] cmd, input int nclk);
    rsp = '0;
    cs_n_o = 1'b0;
    #7.5;
    for (int i = 0; i < nclk; i++) begin
      // past the command, flip sdi so a stale level is never mistaken for data
      sdi_o = (i < CMD_W) ? cmd[CMD_W-1-i] : ~sdi_o;
      #7.5 sclk_o = 1'b1;
      if (i >= CMD_W) rsp[2*CMD_W-1-i] = sdo_i;
      #7.5 sclk_o = 1'b0;
    end
    sdi_o = ~sdi_o;
    #7.5 cs_n_o = 1'b1;
    #15;
    if (nclk > CMD_W) ->got;
  endtask
endmodule

// file: test/test_alarm_low_threshold_and_cmd_readback.sv
// testbench for the low alarm threshold and command read-back bank
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_alarm_low_threshold_and_cmd_readback
  import low_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, resetn_i, sclk, cs_n, sdi, serial_data_output, sdo_oe;
  logic [NUM_CH-1:0][CMD_W-1:0] low_level;
  logic [7:0] prev_cmd;
  logic [7:0] up_m [NUM_CH];
  logic [3:0] lo_m [NUM_CH];
  logic [CMD_W-1:0] last_cmd, e_w;
  logic [CMD_W-1:0] exp_q [$];
  int error_cnt, samples_checked, seed, oe_hi;

  alarm_low_threshold_and_cmd_readback i_alarm_low_threshold_and_cmd_readback (
    .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(serial_data_output), .sdo_oe_o(sdo_oe), .low_level_o(low_level), .prev_cmd_o(prev_cmd));
  host_model i_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(serial_data_output));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // empty queue yields x, so an unexpected answer always mismatches
  always @(i_host_model.got) begin
    e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
    `CHK("sdo word", e_w, i_host_model.rsp)
  end

  // enable must be up from the first falling edge of every frame on
  always @(posedge sclk) begin
    if (sdo_oe === 1'b1) oe_hi++;
  end

  // one frame: note the answer, update the model, then check core-side copies
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d, input int nclk);
    logic [CMD_W-1:0] r;
    logic ok;
    r = '0;
    ok = (nclk > CMD_W);
    for (int n = 0; n < NUM_CH; n++) begin
      if (a == 7'(LOW_UPPER_BASE + CH_STRIDE * n)) begin
        r = {up_m[n], 8'h00};
        if (w && ok) up_m[n] = d;
      end
      if (a == 7'(LOW_LOWER_BASE + CH_STRIDE * n)) begin
        r = {lo_m[n], RO_NIBBLE, PAD_BYTE};
        if (w && ok) lo_m[n] = d[7:4];
      end
    end
    if (a == READBACK_ADDR && !w) r = {last_cmd[15:8], PAD_BYTE};
    if (ok) begin
      exp_q.push_back(r);
      last_cmd = {a, w, d};
    end
    oe_hi = 0;
    i_host_model.frame({a, w, d}, nclk);
    repeat (8) @(posedge clk_i);
    `CHK("sdo oe", nclk - 1, oe_hi)
    `CHK("sdo idle", 2'b00, {sdo_oe, serial_data_output})
    for (int n = 0; n < NUM_CH; n++) begin
      `CHK("low level", {up_m[n], lo_m[n], 4'h0}, low_level[n])
    end
    `CHK("prev cmd", last_cmd[15:8], prev_cmd)
  endtask

  // reset with the link idle; the model forgets every write
  task automatic apply_reset();
    #2 resetn_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #2 resetn_i = 1'b1;
    last_cmd = CMD_RST;
    for (int n = 0; n < NUM_CH; n++) begin
      up_m[n] = LOW_UPPER_RST;
      lo_m[n] = LOW_LOWER_RST;
    end
    `CHK("prev cmd rst", 8'h00, prev_cmd)
    `CHK("level rst", 16'h0000, low_level[0])
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("[ERR] watchdog exp done got hang");
    finish_test();
  end

  initial begin
    seed = 20955;
    error_cnt = 0;
    samples_checked = 0;
    resetn_i = 1'b0;
    apply_reset();
    xfer(LOW_UPPER_BASE, 1'b0, 8'h00, 32);
    xfer(LOW_UPPER_BASE, 1'b1, 8'haa, 32);
    xfer(LOW_LOWER_BASE, 1'b1, 8'hff, 32);
    xfer(LOW_UPPER_BASE, 1'b0, 8'h00, 32);
    xfer(LOW_LOWER_BASE, 1'b0, 8'h00, 32);
    $display("test ch0 registers done");
    for (int n = 1; n < NUM_CH; n++) begin
      xfer(7'(LOW_UPPER_BASE + CH_STRIDE * n), 1'b1, 8'($random(seed)), 32);
      xfer(7'(LOW_LOWER_BASE + CH_STRIDE * n), 1'b1, 8'($random(seed)), 32);
    end
    $display("test channel isolation done");
    xfer(7'h10, 1'b1, 8'h55, 32);
    xfer(7'h10, 1'b0, 8'h00, 32);
    // too few clocks: nothing executes, previous command unchanged
    xfer(LOW_UPPER_BASE, 1'b1, 8'h3c, 12);
    $display("test refused writes done");
    xfer(READBACK_ADDR, 1'b0, 8'h00, 24);
    xfer(READBACK_ADDR, 1'b0, 8'h00, 32);
    xfer(READBACK_ADDR, 1'b1, 8'h12, 32);
    xfer(READBACK_ADDR, 1'b0, 8'h00, 32);
    $display("test command read-back done");
    apply_reset();
    xfer(READBACK_ADDR, 1'b0, 8'h00, 32);
    xfer(LOW_LOWER_BASE, 1'b0, 8'h00, 32);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
